// ==== hdl/chscfg_map.vh ====
// register offsets, reset values and limits of the class-h step level bank
`ifndef CHSCFG_MAP_VH
`define CHSCFG_MAP_VH

`define CHSCFG_PAGE 8'h05
`define CHSCFG_FIRST_OFS 8'h48
`define CHSCFG_LAST_OFS 8'h7F
`define CHSCFG_NUM_WORDS 14

`define CHSCFG_STEP06_OFS 8'h48
`define CHSCFG_STEP07_OFS 8'h4C
`define CHSCFG_STEP08_OFS 8'h50
`define CHSCFG_STEP09_OFS 8'h54
`define CHSCFG_STEP10_OFS 8'h58
`define CHSCFG_STEP11_OFS 8'h5C
`define CHSCFG_STEP12_OFS 8'h60
`define CHSCFG_STEP13_OFS 8'h64
`define CHSCFG_STEP14_OFS 8'h68
`define CHSCFG_STEP15_OFS 8'h6C
`define CHSCFG_STEP16_OFS 8'h70
`define CHSCFG_TRK_DLY_OFS 8'h74
`define CHSCFG_LVS_DLY_OFS 8'h78
`define CHSCFG_GATE_OFS 8'h7C

`define CHSCFG_STEP06_RST 32'h2026F30F
`define CHSCFG_STEP07_RST 32'h198A1357
`define CHSCFG_STEP08_RST 32'h144960C5
`define CHSCFG_STEP09_RST 32'h101D3F2D
`define CHSCFG_STEP10_RST 32'h00CCCCCC
`define CHSCFG_STEP11_RST 32'h0A2AADD1
`define CHSCFG_STEP12_RST 32'h08138561
`define CHSCFG_STEP13_RST 32'h08138561
`define CHSCFG_LOW_STEP_RST 32'h08138561
`define CHSCFG_TRK_DLY_RST 32'h000000BF
`define CHSCFG_LVS_DLY_RST 32'h0000000E
`define CHSCFG_GATE_RST 32'h66676869

`define CHSCFG_LVS_DLY_MAX 32'h0000000F
`define CHSCFG_LAST_BYTE 2'h3
`define CHSCFG_STAGE_FULL 3'h7

`endif

// ==== hdl/chscfg_word.v ====
// one 32-bit configuration word written byte by byte, most significant byte first
`timescale 1ns/1ps
module chscfg_word #(
  parameter [31:0] RESET_VALUE = 32'h00000000
) (
  input wire core_clk,
  input wire srst,
  input wire wr_en,
  input wire [1:0] byte_sel,
  input wire [7:0] wdata,
  output wire [31:0] value
);
`include "chscfg_map.vh"

  reg [31:0] value_q;
  reg [23:0] stage_q;
  reg [2:0] seen_q;

  assign value = value_q;

  // byte 0 is the most significant; the word changes only on the last byte
  // so the datapath never sees a half-updated threshold
  always @(posedge core_clk) begin
    if (srst) begin
      value_q <= RESET_VALUE;
      stage_q <= 24'h000000;
      seen_q <= 3'h0;
    end else if (wr_en) begin
      case (byte_sel)
        2'h0: begin
          stage_q[23:16] <= wdata; // RULE12
          seen_q[0] <= 1'b1;
        end
        2'h1: begin
          stage_q[15:8] <= wdata;
          seen_q[1] <= 1'b1;
        end
        2'h2: begin
          stage_q[7:0] <= wdata;
          seen_q[2] <= 1'b1;
        end
        default: begin
          if (seen_q == `CHSCFG_STAGE_FULL) begin
            value_q <= {stage_q, wdata}; // RULE12
          end
          seen_q <= 3'h0;
        end
      endcase
    end
  end

endmodule // chscfg_word

// ==== hdl/chscfg_bank.v ====
// class-h step level, tracking delay, low-voltage delay and override gate registers
// Operation
// RULE1: each value is one 32-bit read/write word over four byte addresses, page five.
// RULE2: software writes step levels as signed fractions scaled by two to thirty-one.
// RULE3: software derives steps 6-15 from margin, boost minimum and span, over 15.8489.
// RULE4: software sets step 16 to margin times boost minimum over 15.8489.
// RULE5: steps twelve, fourteen, fifteen and sixteen reset to the same word.
// RULE6: tracking delay holds samples minus one; the device applies value plus one.
// RULE7: software should keep the tracking delay under four milliseconds.
// RULE8: at 48 or 96 kHz the low-voltage delay is delay times 96000 minus one, 0-15.
// RULE9: below 48 kHz the low-voltage delay uses twice the sample rate, 0-15.
// RULE10: override is enabled for any non-zero gate word, disabled only at zero.
// RULE11: while override is enabled, the release window is applied to tracking; reset loads the enable as one but the applied window as zero.
// RULE12: most significant byte at lowest address; word applies after all four bytes.
`timescale 1ns/1ps
module chscfg_bank (
  input wire core_clk,
  input wire srst,
  input wire [7:0] page,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] tracking_release_window,
  output reg [7:0] rdata,
  output wire [31:0] class_h_step_level_06,
  output wire [31:0] class_h_step_level_07,
  output wire [31:0] class_h_step_level_08,
  output wire [31:0] class_h_step_level_09,
  output wire [31:0] class_h_step_level_10,
  output wire [31:0] class_h_step_level_11,
  output wire [31:0] class_h_step_level_12,
  output wire [31:0] class_h_step_level_13,
  output wire [31:0] class_h_step_level_14,
  output wire [31:0] class_h_step_level_15,
  output wire [31:0] class_h_step_level_16,
  output wire [31:0] class_h_tracking_delay,
  output wire [31:0] low_voltage_signal_delay,
  output wire [31:0] override_gate_word,
  output reg [32:0] tracking_delay_samples,
  output reg [4:0] low_voltage_delay_samples,
  output reg override_enabled,
  output reg [31:0] release_window_applied
);
`include "chscfg_map.vh"

  localparam NUM_WORDS = `CHSCFG_NUM_WORDS;

  // reset words in index order, word 0 in the low 32 bits
  localparam [32*`CHSCFG_NUM_WORDS-1:0] RESET_VEC = {
    `CHSCFG_GATE_RST,
    `CHSCFG_LVS_DLY_RST,
    `CHSCFG_TRK_DLY_RST,
    `CHSCFG_LOW_STEP_RST, // RULE5
    `CHSCFG_LOW_STEP_RST, // RULE5
    `CHSCFG_LOW_STEP_RST, // RULE5
    `CHSCFG_STEP13_RST,
    `CHSCFG_LOW_STEP_RST, // RULE5
    `CHSCFG_STEP11_RST,
    `CHSCFG_STEP10_RST,
    `CHSCFG_STEP09_RST,
    `CHSCFG_STEP08_RST,
    `CHSCFG_STEP07_RST,
    `CHSCFG_STEP06_RST
  };

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  wire in_window;
  wire [7:0] rel_addr;
  wire [3:0] word_idx;
  wire [1:0] byte_sel;

  assign in_window = (page == `CHSCFG_PAGE) &&
                     (addr >= `CHSCFG_FIRST_OFS) &&
                     (addr <= `CHSCFG_LAST_OFS); // RULE1
  assign rel_addr = addr - `CHSCFG_FIRST_OFS;
  assign word_idx = rel_addr[5:2];
  assign byte_sel = rel_addr[1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // register words

  wire [32*`CHSCFG_NUM_WORDS-1:0] words;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi = gi + 1) begin : g_word
      wire word_wr;
      assign word_wr = wr_stb && in_window && (word_idx == gi); // RULE1
      chscfg_word #(
        .RESET_VALUE(RESET_VEC[32*gi +: 32])
      ) u_word (
        .core_clk(core_clk),
        .srst(srst),
        .wr_en(word_wr),
        .byte_sel(byte_sel),
        .wdata(wdata),
        .value(words[32*gi +: 32])
      );
    end
  endgenerate

  assign class_h_step_level_06 = words[32*0 +: 32];
  assign class_h_step_level_07 = words[32*1 +: 32];
  assign class_h_step_level_08 = words[32*2 +: 32];
  assign class_h_step_level_09 = words[32*3 +: 32];
  assign class_h_step_level_10 = words[32*4 +: 32];
  assign class_h_step_level_11 = words[32*5 +: 32];
  assign class_h_step_level_12 = words[32*6 +: 32];
  assign class_h_step_level_13 = words[32*7 +: 32];
  assign class_h_step_level_14 = words[32*8 +: 32];
  assign class_h_step_level_15 = words[32*9 +: 32];
  assign class_h_step_level_16 = words[32*10 +: 32];
  assign class_h_tracking_delay = words[32*11 +: 32];
  assign low_voltage_signal_delay = words[32*12 +: 32];
  assign override_gate_word = words[32*13 +: 32];

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data stand in the cycle after the strobe only

  reg [31:0] rd_word;
  reg [7:0] rd_byte;

  always @* begin
    rd_word = words[32*word_idx +: 32];
    case (byte_sel)
      2'h0: rd_byte = rd_word[31:24]; // RULE12
      2'h1: rd_byte = rd_word[23:16];
      2'h2: rd_byte = rd_word[15:8];
      default: rd_byte = rd_word[7:0];
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd_stb && in_window) begin
      rdata <= rd_byte; // RULE1
    end else begin
      // unmapped reads and idle cycles answer zero
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // values presented to the class-h controller

  wire [31:0] lvs_clamped;
  wire gate_nonzero;

  // field stays 32 bits wide for software; out-of-range values saturate at
  // the top legal code rather than wrapping to a short delay
  assign lvs_clamped = (low_voltage_signal_delay > `CHSCFG_LVS_DLY_MAX) ?
                       `CHSCFG_LVS_DLY_MAX : low_voltage_signal_delay; // RULE8 RULE9
  assign gate_nonzero = |override_gate_word; // RULE10

  always @(posedge core_clk) begin
    if (srst) begin
      tracking_delay_samples <= {1'b0, `CHSCFG_TRK_DLY_RST} + 33'h000000001;
      low_voltage_delay_samples <= 5'h0F;
      override_enabled <= 1'b1;
      release_window_applied <= 32'h00000000;
    end else begin
      tracking_delay_samples <= {1'b0, class_h_tracking_delay} + 33'h000000001; // RULE6
      low_voltage_delay_samples <= {1'b0, lvs_clamped[3:0]} + 5'h01; // RULE8 RULE9
      override_enabled <= gate_nonzero; // RULE10
      if (gate_nonzero) begin
        release_window_applied <= tracking_release_window; // RULE11
      end else begin
        release_window_applied <= 32'h00000000;
      end
    end
  end

endmodule // chscfg_bank

// ==== test/chscfg_bank_assertions.sv ====
// port-level assertions for the class-h configuration bank
`timescale 1ns/1ps
module chscfg_bank_chk (
  input logic core_clk, srst, wr_stb, rd_stb, override_enabled,
  input logic [7:0] page, addr, wdata, rdata,
  input logic [31:0] tracking_release_window, class_h_step_level_06, class_h_tracking_delay,
  input logic [31:0] low_voltage_signal_delay, override_gate_word, release_window_applied,
  input logic [32:0] tracking_delay_samples,
  input logic [4:0] low_voltage_delay_samples
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_read_quiet: assert property (rdata != 8'h00 |-> $past(rd_stb) && $past(page) == 8'h05)
    else $error("read data without a mapped read");
  chk_foreign_page: assert property (wr_stb && page != 8'h05 |=> $stable(class_h_step_level_06))
    else $error("write on another page changed a word");
  chk_word_commit: assert property ($changed(class_h_step_level_06) |->
    $past(wr_stb && page == 8'h05 && addr == 8'h4B))
    else $error("word changed without a last-byte write");
  chk_low_byte: assert property ($changed(class_h_step_level_06) |->
    class_h_step_level_06[7:0] == $past(wdata))
    else $error("last byte not at highest address");
  chk_track_plus: assert property (tracking_delay_samples ==
    {1'b0, $past(class_h_tracking_delay)} + 33'h1)
    else $error("tracking delay samples wrong");
  chk_lvs_range: assert property (low_voltage_delay_samples == (($past(low_voltage_signal_delay)
    > 32'hF) ? 5'h10 : 5'($past(low_voltage_signal_delay) + 32'h1)))
    else $error("low-voltage delay samples wrong");
  chk_gate_level: assert property (override_enabled == ($past(override_gate_word) != 32'h0))
    else $error("override enable wrong");
  chk_release_pass: assert property (!$past(srst) |-> release_window_applied == (($past(override_gate_word)
    != 32'h0) ? $past(tracking_release_window) : 32'h0))
    else $error("release window wrong");
endmodule // chscfg_bank_chk

// ==== test/chscfg_bank_bench.sv ====
// self-checking bench for the class-h configuration bank
`timescale 1ns/1ps
module chscfg_bank_bench;
  logic core_clk = 0, srst = 1, wr_stb = 0, rd_stb = 0, oen;
  logic [7:0] page = 8'h05, addr = 8'h00, wdata = 8'h00, rdata, b;
  logic [31:0] trw = 32'h5A5AA5A5, rwa, v, wv[14];
  logic [32:0] tds;
  logic [4:0] lds;
  int failures = 0, check_count = 0;
  localparam logic [31:0] RV[14] = '{32'h2026F30F, 32'h198A1357, 32'h144960C5, 32'h101D3F2D,
    32'h00CCCCCC, 32'h0A2AADD1, 32'h08138561, 32'h08138561, 32'h08138561, 32'h08138561,
    32'h08138561, 32'h000000BF, 32'h0000000E, 32'h66676869};
  chscfg_bank DUT (.core_clk, .srst, .page, .addr, .wdata, .wr_stb, .rd_stb,
    .tracking_release_window(trw), .rdata, .class_h_step_level_06(wv[0]),
    .class_h_step_level_07(wv[1]), .class_h_step_level_08(wv[2]), .class_h_step_level_09(wv[3]),
    .class_h_step_level_10(wv[4]), .class_h_step_level_11(wv[5]), .class_h_step_level_12(wv[6]),
    .class_h_step_level_13(wv[7]), .class_h_step_level_14(wv[8]), .class_h_step_level_15(wv[9]),
    .class_h_step_level_16(wv[10]), .class_h_tracking_delay(wv[11]),
    .low_voltage_signal_delay(wv[12]), .override_gate_word(wv[13]),
    .tracking_delay_samples(tds), .low_voltage_delay_samples(lds),
    .override_enabled(oen), .release_window_applied(rwa));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [32:0] g, e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one strobe per access, then a gap cycle; read data is sampled in its only valid cycle
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge core_clk);
    wr_stb <= 0;
    rd_stb <= 0;
    #1;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) acc(1, a + 8'(i), d[31-8*i -: 8]);
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    for (int i = 0; i < 4; i++) begin
      acc(0, a + 8'(i), 8'h00);
      v[31-8*i -: 8] = rdata;
    end
    chk(v, e);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 0;
    for (int i = 0; i < 14; i++) begin
      rd32(8'h48 + 8'(4*i), RV[i]);
      chk(wv[i], RV[i]);
    end
    chk(tds, 33'hC0);
    chk(lds, 5'hF);
    chk(oen, 1);
    for (int i = 0; i < 14; i++) begin
      b = 8'h48 + 8'(4*i);
      wr32(b, {b, ~b, b, 8'hC3});
      rd32(b, {b, ~b, b, 8'hC3});
      chk(wv[i], {b, ~b, b, 8'hC3});
    end
    chk(wv[0], 32'h48B748C3);
    // 2 ms at 48 kHz is 96 samples, written as 95
    wr32(8'h74, 32'h0000005F);
    chk(tds, 33'h060);
    wr32(8'h74, 32'hFFFFFFFF);
    chk(tds, 33'h100000000);
    // 0.1 ms at 96 kHz rounds to 10 samples, written as 9
    wr32(8'h78, 32'h00000009);
    chk(lds, 5'h0A);
    wr32(8'h78, 32'h00000020);
    chk(lds, 5'h10);
    wr32(8'h78, 32'h00000000);
    chk(lds, 5'h01);
    wr32(8'h7C, 32'h00000000);
    chk({oen, rwa}, 33'h0);
    wr32(8'h7C, 32'h00000100);
    chk({oen, rwa}, {1'b1, trw});
    // only bytes 0 and 3 written, bytes 1 and 2 never staged, so the last byte must not commit
    acc(1, 8'h48, 8'hEE);
    acc(1, 8'h4B, 8'hEE);
    rd32(8'h48, 32'h48B748C3);
    @(posedge core_clk);
    page <= 8'h06;
    wr32(8'h48, 32'hFFFFFFFF);
    rd32(8'h48, 32'h0);
    @(posedge core_clk);
    page <= 8'h05;
    rd32(8'h48, 32'h48B748C3);
    acc(0, 8'h47, 8'h00);
    chk(rdata, 8'h00);
    // margin 1, boost minimum 0, boost maximum 15.8489: step n is (16-n)/16
    for (int n = 6; n <= 16; n++) begin
      b = 8'h48 + 8'(4*(n-6));
      wr32(b, 32'(16-n) << 27);
      rd32(b, 32'(16-n) << 27);
    end
    // gate cleared so the reset value alone must re-enable the override
    wr32(8'h7C, 32'h00000000);
    chk(oen, 0);
    @(posedge core_clk);
    srst <= 1;
    repeat (2) @(posedge core_clk);
    srst <= 0;
    rd32(8'h70, 32'h08138561);
    chk(wv[10], RV[10]);
    chk(wv[0], RV[0]);
    chk(oen, 1);
    complete_run;
  end
endmodule // chscfg_bank_bench
bind chscfg_bank chscfg_bank_chk u_chk (.core_clk, .srst, .wr_stb, .rd_stb, .override_enabled,
  .page, .addr, .wdata, .rdata, .tracking_release_window, .class_h_step_level_06,
  .class_h_tracking_delay, .low_voltage_signal_delay, .override_gate_word,
  .release_window_applied, .tracking_delay_samples, .low_voltage_delay_samples);
